/* src/cpl_lock_ctrl.sv */
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "cpl_defs.svh"
module cpl_lock_ctrl #(
    parameter int SECRET_BYTES = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire cpl_pkg::cpl_addr_t reg_addr,
    input  wire cpl_pkg::cpl_word_t reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output cpl_pkg::cpl_word_t     reg_rdata,
    input  wire logic              link_clk,
    input  wire logic              link_frame,
    input  wire logic              link_dat,
    output logic                   card_locked,
    output logic                   lock_op_failure_error,
    output logic                   user_access_en,
    output logic                   user_erase_req
);
    import cpl_pkg::*;

    localparam int AW = $clog2(SECRET_BYTES) + 1;

    function automatic logic [15:0] cpl_crc_step(input logic [15:0] c, input logic b);
        cpl_crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CPL_CRC_POLY : 16'h0000);
    endfunction : cpl_crc_step

    cpl_store_if #(.AW(AW)) st ();

    cpl_secret_store #(.AW(AW)) u_store (
        .clk_sys (clk_sys),
        .st      (st.store)
    );

    // Link pins pass two flops before anything looks at them.
    logic [1:0]  clk_sync_reg;
    logic [1:0]  frm_sync_reg;
    logic [1:0]  dat_sync_reg;
    logic        clk_prev_reg;
    logic        clk_rise;
    logic        frame;
    logic        bit_in;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clk_sync_reg <= 2'h0;
            frm_sync_reg <= 2'h0;
            dat_sync_reg <= 2'h0;
            clk_prev_reg <= 1'b0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], link_clk};
            frm_sync_reg <= {frm_sync_reg[0], link_frame};
            dat_sync_reg <= {dat_sync_reg[0], link_dat};
            clk_prev_reg <= clk_sync_reg[1];
        end
    end

    assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;
    assign frame    = frm_sync_reg[1];
    assign bit_in   = dat_sync_reg[1];

    // Software registers.
    cpl_byte_t   blk_len_reg;
    logic        wipe_cmd;
    logic        clr_err_cmd;

    assign wipe_cmd    = reg_wr && reg_addr == `CPL_OFS_CTRL && reg_wdata[`CPL_CTRL_WIPE];
    assign clr_err_cmd = reg_wr && reg_addr == `CPL_OFS_CTRL && reg_wdata[`CPL_CTRL_CLRERR];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            blk_len_reg <= `CPL_BLKLEN_RST;
        end else if (reg_wr && reg_addr == `CPL_OFS_BLKLEN) begin
            blk_len_reg <= reg_wdata[7:0];
        end
    end

    // Receiver.
    cpl_state_e  state_reg;
    logic        armed_reg;
    logic [2:0]  bit_cnt_reg;
    cpl_byte_t   byte_idx_reg;
    cpl_byte_t   shift_reg;
    logic [15:0] crc_reg;
    logic [4:0]  crc_cnt_reg;
    cpl_byte_t   mode_reg;
    cpl_byte_t   len_reg;
    logic        mismatch_reg;
    logic        capture;
    logic        byte_done;
    cpl_byte_t   byte_val;
    cpl_byte_t   pw_idx;
    cpl_byte_t   new_idx;
    cpl_byte_t   stored_len;
    logic        in_old;

    assign stored_len = st.meta_len;
    assign capture    = clk_rise && frame &&
                        (state_reg == CPL_DATA || state_reg == CPL_CRC || (state_reg == CPL_IDLE && armed_reg));
    assign byte_val   = {shift_reg[6:0], bit_in};
    assign byte_done  = capture && state_reg != CPL_CRC && bit_cnt_reg == `CPL_LAST_BIT;
    assign pw_idx     = byte_idx_reg - `CPL_HDR_BYTES;
    assign new_idx    = pw_idx - stored_len;
    // In a set request the old password occupies the first stored_len bytes.
    assign in_old     = mode_reg[`CPL_BIT_SET] ? (pw_idx < stored_len) : 1'b1;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= CPL_IDLE;
        end else begin
            case (state_reg)
                CPL_IDLE: begin
                    if (capture) begin
                        state_reg <= (blk_len_reg == 8'h01 && bit_cnt_reg == `CPL_LAST_BIT) ? CPL_CRC : CPL_DATA;
                    end
                end
                CPL_DATA: begin
                    if (!frame) begin
                        state_reg <= CPL_IDLE;
                    end else if (byte_done && byte_idx_reg == blk_len_reg - 8'h01) begin
                        state_reg <= CPL_CRC;
                    end
                end
                CPL_CRC: begin
                    if (!frame) begin
                        state_reg <= CPL_IDLE;
                    end else if (capture && crc_cnt_reg == `CPL_LAST_CRC_BIT) begin
                        state_reg <= CPL_EXEC;
                    end
                end
                default: begin
                    state_reg <= CPL_IDLE;
                end
            endcase
        end
    end

    // A new block may start only after the frame has been seen low.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            armed_reg <= 1'b0;
        end else if (state_reg != CPL_IDLE) begin
            armed_reg <= 1'b0;
        end else if (!frame) begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_reg  <= 3'h0;
            byte_idx_reg <= 8'h00;
            shift_reg    <= 8'h00;
            crc_reg      <= `CPL_CRC_INIT;
            crc_cnt_reg  <= 5'h00;
        end else if (state_reg == CPL_IDLE && !capture) begin
            bit_cnt_reg  <= 3'h0;
            byte_idx_reg <= 8'h00;
            crc_reg      <= `CPL_CRC_INIT;
            crc_cnt_reg  <= 5'h00;
        end else if (capture) begin
            crc_reg <= cpl_crc_step(crc_reg, bit_in);
            if (state_reg == CPL_CRC) begin
                crc_cnt_reg <= crc_cnt_reg + 5'h01;
            end else begin
                shift_reg   <= byte_val;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (byte_done) begin
                    byte_idx_reg <= byte_idx_reg + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_reg     <= 8'h00;
            len_reg      <= 8'h00;
            mismatch_reg <= 1'b0;
        end else if (state_reg == CPL_IDLE && !capture) begin
            mode_reg     <= 8'h00;
            len_reg      <= 8'h00;
            mismatch_reg <= 1'b0;
        end else if (byte_done) begin
            if (byte_idx_reg == `CPL_BYTE_MODE) begin
                mode_reg <= byte_val;
            end else if (byte_idx_reg == `CPL_BYTE_LEN) begin
                len_reg <= byte_val;
            end else if (in_old && (pw_idx >= stored_len || byte_val != st.rd_data)) begin
                mismatch_reg <= 1'b1;
            end
        end
    end

    // New password bytes go to the idle bank; the live bank is untouched until commit.
    assign st.rd_addr = {st.meta_bank, pw_idx[AW-2:0]};
    assign st.wr_en   = byte_done && byte_idx_reg >= `CPL_HDR_BYTES && mode_reg[`CPL_BIT_SET] &&
                        !in_old && new_idx < `CPL_SECRET_BYTES;
    assign st.wr_addr = {~st.meta_bank, new_idx[AW-2:0]};
    assign st.wr_data = byte_val;

    // Decision on a complete block.
    logic        exec;
    logic        crc_ok;
    logic        hdr_ok;
    logic        match;
    cpl_byte_t   new_len;
    logic        op_fail;
    logic        op_lock;
    logic        op_unlock;
    logic        op_commit;
    logic        op_clear;
    logic        op_erase;
    logic        locked_reg;

    assign crc_ok  = crc_reg == `CPL_CRC_INIT;
    assign exec    = state_reg == CPL_EXEC && crc_ok;
    assign hdr_ok  = blk_len_reg == len_reg + `CPL_HDR_BYTES;
    assign match   = !mismatch_reg && hdr_ok && len_reg == stored_len;
    assign new_len = len_reg - stored_len;

    always_comb begin
        op_fail   = 1'b0;
        op_lock   = 1'b0;
        op_unlock = 1'b0;
        op_commit = 1'b0;
        op_clear  = 1'b0;
        op_erase  = 1'b0;
        if (mode_reg[`CPL_BIT_ERASE]) begin
            if (mode_reg != `CPL_MODE_ERASE_ONLY || blk_len_reg != `CPL_ERASE_BLOCK) begin
                op_fail = 1'b1;
            end else if (!locked_reg) begin
                op_fail = 1'b1;
            end else begin
                op_erase = 1'b1;
            end
        end else if (mode_reg[`CPL_BIT_CLR]) begin
            if (match && stored_len != 8'h00) begin
                op_clear = 1'b1;
            end else begin
                op_fail = 1'b1;
            end
        end else if (mode_reg[`CPL_BIT_SET]) begin
            if (!mismatch_reg && hdr_ok && len_reg >= stored_len && new_len != 8'h00 &&
                new_len <= `CPL_SECRET_BYTES) begin
                op_commit = 1'b1;
                op_lock   = mode_reg[`CPL_BIT_LOCK];
            end else begin
                op_fail = 1'b1;
            end
        end else if (mode_reg[`CPL_BIT_LOCK]) begin
            if (locked_reg || stored_len == 8'h00 || !match) begin
                op_fail = 1'b1;
            end else begin
                op_lock = 1'b1;
            end
        end else begin
            if (!locked_reg || !match) begin
                op_fail = 1'b1;
            end else begin
                op_unlock = 1'b1;
            end
        end
    end

    // Stored length and bank pointer update.
    always_comb begin
        st.meta_wr      = 1'b0;
        st.meta_bank_in = st.meta_bank;
        st.meta_len_in  = stored_len;
        if (wipe_cmd) begin
            st.meta_wr      = 1'b1;
            st.meta_bank_in = 1'b0;
            st.meta_len_in  = 8'h00;
        end else if (exec && op_commit) begin
            st.meta_wr      = 1'b1;
            st.meta_bank_in = ~st.meta_bank;
            st.meta_len_in  = new_len;
        end else if (exec && (op_clear || op_erase)) begin
            st.meta_wr     = 1'b1;
            st.meta_len_in = 8'h00;
        end
    end

    // Lock state: resolved from the stored length right after reset release.
    logic pwrup_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pwrup_reg  <= 1'b1;
            locked_reg <= 1'b1;
        end else begin
            pwrup_reg <= 1'b0;
            if (wipe_cmd) begin
                locked_reg <= 1'b0;
            end else if (pwrup_reg) begin
                locked_reg <= stored_len != 8'h00;
            end else if (exec && op_lock) begin
                locked_reg <= 1'b1;
            end else if (exec && (op_unlock || op_erase)) begin
                locked_reg <= 1'b0;
            end
        end
    end

    // Sticky flags and the one-cycle erase request; for the sticky flags a new event wins over a software clear in the same cycle.
    logic fail_reg;
    logic crc_err_reg;
    logic erased_reg;
    logic erase_req_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fail_reg      <= 1'b0;
            crc_err_reg   <= 1'b0;
            erased_reg    <= 1'b0;
            erase_req_reg <= 1'b0;
        end else begin
            erase_req_reg <= exec && op_erase;
            if (exec && op_fail) begin
                fail_reg <= 1'b1;
            end else if (clr_err_cmd) begin
                fail_reg <= 1'b0;
            end
            if ((state_reg == CPL_EXEC && !crc_ok) ||
                ((state_reg == CPL_DATA || state_reg == CPL_CRC) && !frame)) begin
                crc_err_reg <= 1'b1;
            end else if (clr_err_cmd) begin
                crc_err_reg <= 1'b0;
            end
            if (exec && op_erase) begin
                erased_reg <= 1'b1;
            end else if (clr_err_cmd) begin
                erased_reg <= 1'b0;
            end
        end
    end

    // Register read port, data one cycle after the strobe.
    cpl_word_t rdata_reg;
    cpl_word_t status_word;

    always_comb begin
        status_word                                  = 32'h0000_0000;
        status_word[`CPL_ST_LOCKED]                  = locked_reg;
        status_word[`CPL_ST_FAIL]                    = fail_reg;
        status_word[`CPL_ST_CRCERR]                  = crc_err_reg;
        status_word[`CPL_ST_BUSY]                    = state_reg != CPL_IDLE;
        status_word[`CPL_ST_ERASED]                  = erased_reg;
        status_word[`CPL_ST_LEN_LO +: 8]             = stored_len;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `CPL_OFS_STATUS) begin
                rdata_reg <= status_word;
            end else if (reg_addr == `CPL_OFS_BLKLEN) begin
                rdata_reg <= {24'h00_0000, blk_len_reg};
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata             = rdata_reg;
    assign card_locked           = locked_reg;
    assign lock_op_failure_error = fail_reg;
    assign user_access_en        = !locked_reg;
    assign user_erase_req        = erase_req_reg;
endmodule : cpl_lock_ctrl

/* include/cpl_defs.svh */
`ifndef CPL_DEFS_SVH
`define CPL_DEFS_SVH

// Register offsets on the software port.
`define CPL_OFS_CTRL        4'h0
`define CPL_OFS_BLKLEN      4'h4
`define CPL_OFS_STATUS      4'h8

// Control register bits, each acts as a one-cycle command when written as one.
`define CPL_CTRL_WIPE       0
`define CPL_CTRL_CLRERR     1

// Status register fields.
`define CPL_ST_LOCKED       0
`define CPL_ST_FAIL         1
`define CPL_ST_CRCERR       2
`define CPL_ST_BUSY         3
`define CPL_ST_ERASED       4
`define CPL_ST_LEN_LO       8

// Mode byte flag positions and the only legal forced-erase mode byte.
`define CPL_BIT_ERASE       3
`define CPL_BIT_LOCK        2
`define CPL_BIT_CLR         1
`define CPL_BIT_SET         0
`define CPL_MODE_ERASE_ONLY 8'h08

// Block layout and limits.
`define CPL_BYTE_MODE       8'h00
`define CPL_BYTE_LEN        8'h01
`define CPL_HDR_BYTES       8'h02
`define CPL_ERASE_BLOCK     8'h01
`define CPL_SECRET_BYTES    8'h10
`define CPL_LAST_BIT        3'h7
`define CPL_LAST_CRC_BIT    5'h0f
`define CPL_CRC_POLY        16'h1021
`define CPL_CRC_INIT        16'h0000
`define CPL_BLKLEN_RST      8'h01

`endif

/* include/cpl_pkg.sv */
package cpl_pkg;

    typedef logic [7:0]  cpl_byte_t;
    typedef logic [3:0]  cpl_addr_t;
    typedef logic [31:0] cpl_word_t;

    // Gray sequence along idle, data, crc, exec.
    typedef enum logic [1:0] {
        CPL_IDLE = 2'b00,
        CPL_DATA = 2'b01,
        CPL_CRC  = 2'b11,
        CPL_EXEC = 2'b10
    } cpl_state_e;

endpackage : cpl_pkg

/* include/cpl_store_if.sv */
`timescale 1ns/1ps
interface cpl_store_if #(parameter int AW = 5);
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_data;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    logic          meta_wr;
    logic          meta_bank_in;
    logic [7:0]    meta_len_in;
    logic          meta_bank;
    logic [7:0]    meta_len;

    modport ctrl (output rd_addr, wr_en, wr_addr, wr_data, meta_wr, meta_bank_in, meta_len_in,
                  input  rd_data, meta_bank, meta_len);
    modport store (input  rd_addr, wr_en, wr_addr, wr_data, meta_wr, meta_bank_in, meta_len_in,
                   output rd_data, meta_bank, meta_len);
endinterface : cpl_store_if

/* src/cpl_secret_store.sv */
`timescale 1ns/1ps
// Two banks of secret bytes plus the bank pointer and stored length.
// Nothing here is reset: it models storage that survives power cycles.
module cpl_secret_store #(
    parameter int AW = 5
) (
    input wire logic clk_sys,
    cpl_store_if.store st
);
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] rd_data_reg;
    logic       bank_reg;
    logic [7:0] len_reg;

    always_ff @(posedge clk_sys) begin
        if (st.wr_en) begin
            mem[st.wr_addr] <= st.wr_data;
        end
        rd_data_reg <= mem[st.rd_addr];
    end

    always_ff @(posedge clk_sys) begin
        if (st.meta_wr) begin
            bank_reg <= st.meta_bank_in;
            len_reg  <= st.meta_len_in;
        end
    end

    assign st.rd_data   = rd_data_reg;
    assign st.meta_bank = bank_reg;
    assign st.meta_len  = len_reg;
endmodule : cpl_secret_store

/* verification/cpl_host_model.sv */
`timescale 1ns/1ps
// Host side of the card link: frames one block, clock toggles only inside frames.
module cpl_host_model (
    input  wire logic clk_sys,
    output logic      link_clk,
    output logic      link_frame,
    output logic      link_dat
);
    import cpl_pkg::*;

    initial begin
        link_clk = 1'b0;
        link_frame = 1'b0;
        link_dat = 1'b0;
    end

    // Four system cycles per phase gives the 320 ns link period.
    task automatic put_bit(input logic b);
        link_dat <= b;
        repeat (4) @(posedge clk_sys);
        link_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        link_clk <= 1'b0;
    endtask : put_bit

    task automatic send(input cpl_byte_t blk[$], input logic bad);
        logic [15:0] crc;
        crc = 16'h0000;
        @(posedge clk_sys);
        link_frame <= 1'b1;
        repeat (4) @(posedge clk_sys);
        foreach (blk[i]) begin
            for (int k = 7; k >= 0; k--) begin
                put_bit(blk[i][k]);
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ blk[i][k]) ? 16'h1021 : 16'h0000);
            end
        end
        if (bad) begin
            crc = ~crc;
        end
        for (int k = 15; k >= 0; k--) begin
            put_bit(crc[k]);
        end
        repeat (12) @(posedge clk_sys);
        link_frame <= 1'b0;
        // A released line shows the inverse of its last value.
        link_dat <= ~link_dat;
    endtask : send
endmodule : cpl_host_model

/* verification/cpl_lock_ctrl_props.sv */
`timescale 1ns/1ps
`include "cpl_defs.svh"
module cpl_lock_ctrl_props #(
    parameter int SECRET_BYTES = 16
) (
    input wire logic               clk_sys,
    input wire logic               resetn,
    input wire cpl_pkg::cpl_addr_t reg_addr,
    input wire cpl_pkg::cpl_word_t reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire cpl_pkg::cpl_word_t reg_rdata,
    input wire logic               link_clk,
    input wire logic               link_frame,
    input wire logic               link_dat,
    input wire logic               card_locked,
    input wire logic               lock_op_failure_error,
    input wire logic               user_access_en,
    input wire logic               user_erase_req
);
    import cpl_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    logic [3:0] idle_cnt_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_reg <= 4'h0;
        end else if (link_frame) begin
            idle_cnt_reg <= 4'h0;
        end else if (idle_cnt_reg != 4'hf) begin
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    property p_access;
        user_access_en == !card_locked;
    endproperty
    property p_erase_unlocks;
        user_erase_req |-> !card_locked;
    endproperty
    property p_erase_pulse;
        user_erase_req |=> !user_erase_req;
    endproperty
    property p_erase_was_locked;
        $rose(user_erase_req) |-> $past(card_locked, 2);
    endproperty
    property p_frame_lock_hold;
        $rose(link_frame) |=> $stable(card_locked) [*8];
    endproperty
    property p_frame_fail_hold;
        $rose(link_frame) |=> $stable(lock_op_failure_error) [*8];
    endproperty
    property p_fail_sticky;
        lock_op_failure_error && !(reg_wr && reg_addr == `CPL_OFS_CTRL && reg_wdata[`CPL_CTRL_CLRERR])
            |=> lock_op_failure_error;
    endproperty
    property p_idle_hold;
        (idle_cnt_reg >= 4'h8) && !$past(reg_wr) |-> $stable(card_locked);
    endproperty

    a_access: assert property (p_access) else $error("access enable disagrees with lock");
    a_erase_unlocks: assert property (p_erase_unlocks) else $error("erase while locked");
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase request too long");
    a_erase_was_locked: assert property (p_erase_was_locked) else $error("erase on open card");
    a_frame_lock_hold: assert property (p_frame_lock_hold) else $error("lock moved early");
    a_frame_fail_hold: assert property (p_frame_fail_hold) else $error("failure moved early");
    a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped");
    a_idle_hold: assert property (p_idle_hold) else $error("lock moved without block");

    c_lock: cover property ($rose(card_locked));
    c_unlock: cover property ($fell(card_locked));
    c_erase: cover property (user_erase_req);
    c_fail: cover property ($rose(lock_op_failure_error));
endmodule : cpl_lock_ctrl_props

bind cpl_lock_ctrl cpl_lock_ctrl_props #(.SECRET_BYTES(SECRET_BYTES)) u_props (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .link_frame(link_frame), .link_dat(link_dat), .card_locked(card_locked),
    .lock_op_failure_error(lock_op_failure_error), .user_access_en(user_access_en),
    .user_erase_req(user_erase_req)
);

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "cpl_defs.svh"
module tb_top;
    import cpl_pkg::*;
    typedef cpl_byte_t cpl_bq_t[$];
    logic      clk_sys, resetn, reg_wr, reg_rd, link_clk, link_frame, link_dat;
    logic      card_locked, lock_op_failure_error, user_access_en, user_erase_req;
    cpl_addr_t reg_addr;
    cpl_word_t reg_wdata, reg_rdata;
    int        fails, samples_checked, erase_seen, exp_erases, erase_mark;
    cpl_bq_t   exp_pw;
    logic      exp_locked;

    cpl_lock_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
        .link_frame(link_frame), .link_dat(link_dat), .card_locked(card_locked),
        .lock_op_failure_error(lock_op_failure_error), .user_access_en(user_access_en),
        .user_erase_req(user_erase_req));
    cpl_host_model hm (.clk_sys(clk_sys), .link_clk(link_clk), .link_frame(link_frame), .link_dat(link_dat));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (user_erase_req === 1'b1) erase_seen++;
    end

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check_word(input string what, input cpl_word_t exp, input cpl_word_t got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_word

    task automatic check_count(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count

    task automatic bus_wr(input cpl_addr_t a, input cpl_word_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input cpl_addr_t a, output cpl_word_t d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : bus_rd

    task automatic chk_st(input string name, input logic f, input logic bad);
        cpl_word_t st;
        bus_rd(`CPL_OFS_STATUS, st);
        check_word(name, {16'h0, 8'(exp_pw.size()), 3'h0, exp_erases != erase_mark, 1'b0, bad, f, exp_locked},
                   st & 32'h0000ff17);
        check_word({name, " pins"}, {29'h0, exp_locked, f, !exp_locked},
                   {29'h0, card_locked, lock_op_failure_error, user_access_en});
        check_count(name, exp_erases, erase_seen);
        erase_mark = exp_erases;
        $display("test %s done", name);
    endtask : chk_st

    function automatic logic predict(input cpl_bq_t b);
        int s, n, l;
        logic ok;
        s = exp_pw.size();
        n = b.size();
        l = (n > 1) ? int'(b[1]) : 0;
        ok = (n == l + 2);
        for (int i = 0; i < s && i + 2 < n; i++) ok &= (b[i + 2] == exp_pw[i]);
        if (b[0][3]) begin
            ok = (b[0] == 8'h08) && (n == 1) && exp_locked;
            if (ok) begin
                exp_pw = {};
                exp_locked = 1'b0;
                exp_erases++;
            end
        end else if (b[0][0]) begin
            ok &= (l > s) && (l - s <= 16);
            if (ok) exp_pw = b[2 + s:n - 1];
            if (ok) exp_locked |= b[0][2];
        end else if (b[0][1]) begin
            ok &= (l == s) && (s != 0);
            if (ok) exp_pw = {};
        end else begin
            ok &= (l == s) && (s != 0) && (exp_locked != b[0][2]);
            if (ok) exp_locked = b[0][2];
        end
        return !ok;
    endfunction : predict

    function automatic cpl_bq_t mk(input cpl_byte_t m, input logic wrong, input int nl);
        cpl_bq_t q;
        q = {m, 8'(exp_pw.size() + nl)};
        foreach (exp_pw[i]) q.push_back(exp_pw[i]);
        if (wrong) q[q.size() - 1] ^= 8'h01;
        repeat (nl) q.push_back(8'($urandom));
        return q;
    endfunction : mk

    task automatic run_op(input string name, input cpl_bq_t blk, input logic bad);
        logic f;
        bus_wr(`CPL_OFS_CTRL, 32'h2);
        bus_wr(`CPL_OFS_BLKLEN, 32'(blk.size()));
        hm.send(blk, bad);
        f = bad ? 1'b0 : predict(blk);
        chk_st(name, f, bad);
    endtask : run_op

    task automatic pwr_cycle(input string name);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        exp_locked = (exp_pw.size() != 0);
        chk_st(name, 1'b0, 1'b0);
    endtask : pwr_cycle

    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        end_of_test();
    end

    initial begin
        cpl_word_t d;
        cpl_byte_t m;
        static cpl_byte_t modes[6] = '{8'h01, 8'h05, 8'h04, 8'h00, 8'h02, 8'h08};
        {reg_addr, reg_wdata, reg_wr, reg_rd, resetn} = '0;
        {fails, samples_checked, erase_seen, exp_erases, erase_mark} = '0;
        void'($urandom(48972));
        repeat (14) @(posedge clk_sys);
        // The stored secret has no reset, so it is wiped while reset still holds.
        bus_wr(`CPL_OFS_CTRL, 32'h1);
        resetn <= 1'b1;
        bus_rd(`CPL_OFS_BLKLEN, d);
        check_word("blklen reset", 32'h1, d);
        bus_rd(4'hc, d);
        check_word("unmapped read", 32'h0, d);
        exp_pw = {};
        exp_locked = 1'b0;
        run_op("unlock open", mk(8'h00, 0, 0), 0);
        run_op("lock no secret", mk(8'h04, 0, 0), 0);
        run_op("set and lock", mk(8'h05, 0, 16), 0);
        run_op("lock locked", mk(8'h04, 0, 0), 0);
        run_op("unlock wrong", mk(8'h00, 1, 0), 0);
        run_op("unlock", mk(8'h00, 0, 0), 0);
        run_op("erase open", '{8'h08}, 0);
        run_op("bad crc", mk(8'h01, 0, 4), 1);
        run_op("replace wrong", mk(8'h01, 1, 3), 0);
        run_op("replace", mk(8'h01, 0, 3), 0);
        pwr_cycle("relock");
        run_op("erase extra flag", '{8'h0c}, 0);
        run_op("erase", '{8'h08}, 0);
        run_op("set", mk(8'h01, 0, 2), 0);
        run_op("clear wrong", mk(8'h02, 1, 0), 0);
        run_op("clear", mk(8'h02, 0, 0), 0);
        pwr_cycle("no secret");
        repeat (12) begin
            m = modes[$urandom_range(5)];
            if (m == 8'h02 && exp_locked) m = 8'h00;
            if (m == 8'h08) begin
                run_op("random erase", '{m | 8'($urandom_range(1))}, 0);
            end else begin
                run_op("random op", mk(m, $urandom_range(3) == 0, m[0] ? $urandom_range(8, 1) : 0), 0);
            end
        end
        end_of_test();
    end
endmodule : tb_top
